// ==== common/bald_defines.svh ====
// Timing counts, widths and reset values of the byte datapath
`ifndef BALD_DEFINES_SVH
`define BALD_DEFINES_SVH
`define BALD_CLK_PERIOD_NS 25
`define BALD_OSC_PER_MCYC 12
`define BALD_MCYC_NS (`BALD_OSC_PER_MCYC * `BALD_CLK_PERIOD_NS)
`define BALD_PH_W 4
`define BALD_PH_LAST 4'hB
`define BALD_MC_SHORT 2'h1
`define BALD_MC_LONG 2'h2
`define BALD_LEN_ONE 2'h1
`define BALD_LEN_TWO 2'h2
`define BALD_LEN_THREE 2'h3
`define BALD_ACC_RST 8'h00
`define BALD_CY_BIT 8
`define BALD_AC_BIT 4
`define BALD_SIGN_BIT 7
`endif

// ==== common/bald_pkg.sv ====
// Types shared by the byte datapath and its decoder
package bald_pkg;
   typedef enum logic [2:0] {
      BALD_OP_ADD = 3'h0,
      BALD_OP_SUM_WITH_CARRY = 3'h1,
      BALD_OP_MINUS_WITH_BORROW = 3'h2,
      BALD_OP_AND = 3'h3,
      BALD_OP_OR = 3'h4,
      BALD_OP_XOR = 3'h5
   } bald_op_e;
   typedef enum logic [1:0] {
      BALD_SRC_BANK_REG = 2'h0,
      BALD_SRC_DIRECT = 2'h1,
      BALD_SRC_INDIRECT = 2'h2,
      BALD_SRC_IMM = 2'h3
   } bald_src_e;
   typedef enum logic [1:0] {
      BALD_DST_ACC = 2'h0,
      BALD_DST_DIR_ACC = 2'h1,
      BALD_DST_DIR_IMM = 2'h2
   } bald_dst_e;
   typedef enum logic {
      BALD_ST_IDLE = 1'b0,
      BALD_ST_EXEC = 1'b1
   } bald_state_e;
   typedef struct packed {
      bald_op_e op;
      bald_src_e src;
      bald_dst_e dst;
      logic [7:0] operand;
      logic [7:0] imm;
      logic [7:0] dir_addr;
      logic [7:0] dir_val;
   } bald_req_s;
   typedef struct packed {
      logic cy;
      logic ac;
      logic ov;
   } bald_flags_s;
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } bald_wb_s;
endpackage

// ==== hw/bald_datapath.sv ====
// Byte arithmetic and logic datapath with accumulator and flags
//
// How it works
// - Add of a register, direct, indirect or immediate byte: one cycle.
// - Add with carry adds source plus carry flag in one machine cycle.
// - Subtract with borrow takes source and carry from the accumulator.
// - AND into the accumulator from any source takes one machine cycle.
// - AND of immediate into a direct byte: 3 bytes, 2 machine cycles.
// - AND of accumulator into a direct byte: 2 bytes, 1 machine cycle.
// - OR into the accumulator from any source takes one machine cycle.
// - OR of immediate into a direct byte: 3 bytes, 2 machine cycles.
// - OR of accumulator into a direct byte: 2 bytes, 1 machine cycle.
`include "bald_defines.svh"
module bald_datapath (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic req_valid_i,
   input wire bald_pkg::bald_req_s req_i,
   output logic ready_o,
   output logic done_o,
   output logic [1:0] len_o,
   output logic [7:0] acc_o,
   output bald_pkg::bald_flags_s flags_o,
   output bald_pkg::bald_wb_s wb_o
);
   // Sequencer, latched request and architectural state
   bald_pkg::bald_state_e state_r;
   bald_pkg::bald_state_e state_nxt;
   bald_pkg::bald_req_s req_r;
   logic [`BALD_PH_W-1:0] phase_r;
   logic [`BALD_PH_W-1:0] phase_nxt;
   logic [1:0] mc_left_r;
   logic [1:0] mc_left_nxt;
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   bald_pkg::bald_flags_s flags_r;
   bald_pkg::bald_flags_s flags_nxt;
   bald_pkg::bald_wb_s wb_r;
   bald_pkg::bald_wb_s wb_nxt;
   logic done_r;
   logic [1:0] len_r;
   logic [1:0] len_nxt;

   // Request hand-off and end of the last machine cycle
   // Nothing is queued: a request seen while busy is simply ignored, so
   // the decoder must keep it up until ready has been seen high
   wire take = (state_r == bald_pkg::BALD_ST_IDLE) && req_valid_i;
   wire mc_end = (phase_r == `BALD_PH_LAST);
   wire finish = (state_r == bald_pkg::BALD_ST_EXEC) && mc_end
                 && (mc_left_r == `BALD_MC_SHORT);

   // Instruction length and duration from operand form
   // Worked out from the live request, since both are latched at the take;
   // a direct destination sets the length whatever the source is
   wire src_long = (req_i.src == bald_pkg::BALD_SRC_DIRECT) ||
                   (req_i.src == bald_pkg::BALD_SRC_IMM);
   wire dst_imm = (req_i.dst == bald_pkg::BALD_DST_DIR_IMM);
   wire dst_dacc = (req_i.dst == bald_pkg::BALD_DST_DIR_ACC);
   wire [1:0] len_req = dst_imm ? `BALD_LEN_THREE :
                        dst_dacc ? `BALD_LEN_TWO :
                        src_long ? `BALD_LEN_TWO :
                        `BALD_LEN_ONE;
   wire [1:0] mc_req = dst_imm ? `BALD_MC_LONG :
                       `BALD_MC_SHORT;

   // Operand selection; a direct destination reads its old byte first
   // The decoder hands over that old byte with the request, so this block
   // never reads memory itself; the new byte leaves on the write-back port
   wire to_dir = (req_r.dst != bald_pkg::BALD_DST_ACC);
   wire [7:0] op_a = to_dir ? req_r.dir_val : acc_r;
   wire [7:0] op_b = (req_r.dst == bald_pkg::BALD_DST_DIR_IMM) ? req_r.imm :
                     (req_r.dst == bald_pkg::BALD_DST_DIR_ACC) ? acc_r :
                     req_r.operand;
   wire use_cy = (req_r.op == bald_pkg::BALD_OP_SUM_WITH_CARRY) ||
                 (req_r.op == bald_pkg::BALD_OP_MINUS_WITH_BORROW);
   wire cin = use_cy & flags_r.cy;

   // Nine-bit sum and difference; bit 8 is carry or borrow
   // Carry-in is forced low for plain add and for the logic forms
   wire [8:0] sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
   wire [4:0] sum_lo = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} +
                       {4'h0, cin};
   wire [8:0] dif9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
   wire [4:0] dif_lo = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} -
                       {4'h0, cin};
   wire is_sub = (req_r.op == bald_pkg::BALD_OP_MINUS_WITH_BORROW);
   wire is_arith = (req_r.op == bald_pkg::BALD_OP_ADD) || use_cy;

   // Overflow: sign of result disagrees with what the operand signs imply
   // Carry-in does not enter the sign test, only the result bit does
   wire sa = op_a[`BALD_SIGN_BIT];
   wire sb = op_b[`BALD_SIGN_BIT];
   wire add_ov = (sa == sb) && (sum9[`BALD_SIGN_BIT] != sa);
   wire sub_ov = (sa != sb) && (dif9[`BALD_SIGN_BIT] != sa);

   // Result mux; logic forms never touch the flags
   logic [7:0] result;
   always_comb begin
      case (req_r.op)
         bald_pkg::BALD_OP_ADD: result = sum9[7:0];
         bald_pkg::BALD_OP_SUM_WITH_CARRY: result = sum9[7:0];
         bald_pkg::BALD_OP_MINUS_WITH_BORROW: result = dif9[7:0];
         bald_pkg::BALD_OP_AND: result = op_a & op_b;
         bald_pkg::BALD_OP_OR: result = op_a | op_b;
         bald_pkg::BALD_OP_XOR: result = op_a ^ op_b;
         default: result = op_a;
      endcase
   end

   // Sequencer: twelve clocks per machine cycle, counted per instruction
   // A two-cycle form just runs the phase counter round twice; the cost is
   // a dead idle clock between instructions, traded for flop-only outputs
   always_comb begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      mc_left_nxt = mc_left_r;
      case (state_r)
         bald_pkg::BALD_ST_IDLE: begin
            phase_nxt = '0;
            if (take) begin
               state_nxt = bald_pkg::BALD_ST_EXEC;
               mc_left_nxt = mc_req;
            end
         end
         bald_pkg::BALD_ST_EXEC: begin
            phase_nxt = mc_end ? '0 : phase_r + `BALD_PH_W'(1);
            if (mc_end) begin
               mc_left_nxt = mc_left_r - 2'h1;
            end
            if (finish) begin
               state_nxt = bald_pkg::BALD_ST_IDLE;
            end
         end
         default: begin
            state_nxt = bald_pkg::BALD_ST_IDLE;
            phase_nxt = '0;
         end
      endcase
   end

   // Commit at the close of the last machine cycle
   // Arithmetic aimed at a direct byte still writes back but leaves the
   // flags alone, as the flags belong to accumulator results only
   always_comb begin
      acc_nxt = acc_r;
      flags_nxt = flags_r;
      wb_nxt = '0;
      len_nxt = take ? len_req : len_r;
      if (finish) begin
         if (to_dir) begin
            wb_nxt.en = 1'b1;
            wb_nxt.addr = req_r.dir_addr;
            wb_nxt.data = result;
         end else begin
            acc_nxt = result;
         end
         if (is_arith && !to_dir) begin
            flags_nxt.cy = is_sub ? dif9[`BALD_CY_BIT] : sum9[`BALD_CY_BIT];
            flags_nxt.ac = is_sub ? dif_lo[`BALD_AC_BIT]
                           : sum_lo[`BALD_AC_BIT];
            flags_nxt.ov = is_sub ? sub_ov : add_ov;
         end
      end
   end

   // State and datapath registers
   // The request is latched at the take so the decoder may move on at once
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r <= bald_pkg::BALD_ST_IDLE;
         phase_r <= '0;
         mc_left_r <= '0;
         req_r <= '0;
         len_r <= '0;
      end else begin
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         mc_left_r <= mc_left_nxt;
         len_r <= len_nxt;
         if (take) begin
            req_r <= req_i;   // Held so operands may change during execution
         end
      end
   end

   // Architectural state and output strobes
   // Accumulator and flags only move on a commit; nothing else writes them
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_r <= `BALD_ACC_RST;
         flags_r <= '0;
         wb_r <= '0;
         done_r <= 1'b0;
      end else begin
         acc_r <= acc_nxt;
         flags_r <= flags_nxt;
         wb_r <= wb_nxt;
         done_r <= finish;
      end
   end

   // Ready is a flop: high whenever the sequencer will take a request
   // Reset leaves the block idle, so ready leaves reset already high
   logic ready_r;
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ready_r <= 1'b1;
      end else begin
         ready_r <= (state_nxt == bald_pkg::BALD_ST_IDLE);
      end
   end

   // Every output comes straight from a flop
   assign ready_o = ready_r;
   assign done_o = done_r;
   assign len_o = len_r;
   assign acc_o = acc_r;
   assign flags_o = flags_r;
   assign wb_o = wb_r;
endmodule

// ==== bench/bald_mem_model.sv ====
// Internal data memory model behind the direct forms
module bald_mem_model (
   input wire logic mclk_i,
   input wire bald_pkg::bald_wb_s wb_i,
   input wire logic [7:0] addr_i,
   output logic [7:0] rd_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   // Distinct start pattern so a lost write shows up
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   assign rd_o = mem[addr_i];
   // Write-back takes effect at the edge that carries the pulse
   always @(posedge mclk_i) if (wb_i.en) mem[wb_i.addr] <= wb_i.data;
endmodule

// ==== bench/bald_props.sv ====
// Timing, handshake and flag checks on the byte datapath
module bald_props (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic req_valid_i,
   input wire bald_pkg::bald_req_s req_i,
   input wire logic ready_o,
   input wire logic done_o,
   input wire logic [1:0] len_o,
   input wire logic [7:0] acc_o,
   input wire bald_pkg::bald_flags_s flags_o,
   input wire bald_pkg::bald_wb_s wb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   logic tk, dimm, dacc, lg_r;
   // Request taken, and which destination it names
   assign tk = ready_o && req_valid_i;
   assign dimm = req_i.dst == bald_pkg::BALD_DST_DIR_IMM;
   assign dacc = req_i.dst == bald_pkg::BALD_DST_DIR_ACC;
   // Remember whether the running op is a logic op
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) lg_r <= 1'b0;
      else if (tk) lg_r <= req_i.op >= bald_pkg::BALD_OP_AND;
   end
   a_short_done: assert property (
      tk && !dimm |-> ##1 !done_o [*8] ##1 !done_o [*4] ##1 done_o)
      else $error("short");
   a_long_done: assert property (
      tk && dimm |-> ##13 !done_o ##12 done_o) else $error("long");
   a_busy_hold: assert property (
      tk |=> !ready_o [*8]) else $error("busy");
   a_done_pulse: assert property (
      done_o |-> ready_o ##1 !done_o) else $error("pulse");
   a_len_three: assert property (
      tk && dimm |=> len_o == 2'h3) else $error("len3");
   a_len_two: assert property (
      tk && dacc |=> len_o == 2'h2) else $error("len2");
   a_flags_keep: assert property (
      done_o && lg_r |-> flags_o == $past(flags_o)) else $error("flags");
   a_acc_hold: assert property (
      !done_o |-> $stable(acc_o)) else $error("acc");
   a_wb_with_done: assert property (
      wb_o.en |-> done_o) else $error("wb");
   c_imm: cover property (tk && dimm);
   c_acc: cover property (tk && dacc);
   c_wb: cover property (wb_o.en);
endmodule
bind bald_datapath bald_props chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o),
   .done_o(done_o), .len_o(len_o), .acc_o(acc_o), .flags_o(flags_o),
   .wb_o(wb_o));

// ==== bench/byte_arith_logic_datapath_test.sv ====
// Self-checking bench for the byte datapath
`include "bald_defines.svh"
module byte_arith_logic_datapath_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic req_valid_i = 1'b0;
   bald_pkg::bald_req_s req_i = '0;
   logic ready_o, done_o;
   logic [1:0] len_o;
   logic [7:0] acc_o, rd;
   bald_pkg::bald_flags_s flags_o;
   bald_pkg::bald_wb_s wb_o;
   logic [7:0] ea = 8'h00;
   logic [2:0] ef = 3'h0;
   logic [7:0] rv, ri, ra;
   int err_count = 0;
   int num_checks = 0;
   bald_datapath DUT (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .ready_o(ready_o),
      .done_o(done_o), .len_o(len_o), .acc_o(acc_o), .flags_o(flags_o),
      .wb_o(wb_o));
   bald_mem_model mem (.mclk_i(mclk_i), .wb_i(wb_o),
      .addr_i(req_i.dir_addr), .rd_o(rd));
   initial forever #12.5 mclk_i = ~mclk_i;
   task automatic complete_run;
      if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %0h want %0h", $time, got, exp);
      end
   endtask
   // Returns {cy, ac, ov, result}; carry acts as borrow on subtract
   function automatic logic [10:0] calc(int op, logic [7:0] a,
      logic [7:0] b, logic c);
      logic [8:0] s;
      logic [4:0] h;
      logic ci;
      ci = (op == 1 || op == 2) ? c : 1'b0;
      s = (op == 2) ? {1'b0, a} - b - ci : a + b + ci;
      h = (op == 2) ? {1'b0, a[3:0]} - b[3:0] - ci : a[3:0] + b[3:0] + ci;
      if (op == 3) s[7:0] = a & b;
      if (op == 4) s[7:0] = a | b;
      if (op == 5) s[7:0] = a ^ b;
      return {s[8], h[4], ((a[7] ^ b[7]) == (op == 2)) && s[7] != a[7],
         s[7:0]};
   endfunction
   // One instruction: present, wait for commit, compare everything
   task automatic run(int op, int src, int dst, logic [7:0] v,
      logic [7:0] im, logic [7:0] ad);
      logic [10:0] r;
      logic [16:0] ew;
      int n;
      @(negedge mclk_i);
      req_i.dir_addr = ad;
      #1;
      req_i.op = bald_pkg::bald_op_e'(op);
      req_i.src = bald_pkg::bald_src_e'(src);
      req_i.dst = bald_pkg::bald_dst_e'(dst);
      req_i.operand = v;
      req_i.imm = im;
      req_i.dir_val = rd;
      req_valid_i = 1'b1;
      @(posedge mclk_i);
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 40) begin
         @(negedge mclk_i);
         n++;
      end
      chk(n, (dst == 2 ? 2 : 1) * `BALD_OSC_PER_MCYC);
      chk(len_o, dst == 2 ? 3 : (dst == 1 || src[0]) ? 2 : 1);
      r = calc(op, dst == 0 ? ea : req_i.dir_val,
         dst == 0 ? v : dst == 1 ? ea : im, ef[2]);
      if (dst == 0) ea = r[7:0];
      if (dst == 0 && op < 3) ef = r[10:8];
      ew = (dst == 0) ? 17'h0 : {1'b1, ad, r[7:0]};
      chk({wb_o, flags_o, acc_o}, {ew, ef, ea});
   endtask
   initial begin
      void'($urandom(79));
      repeat (8) @(posedge mclk_i);
      @(negedge mclk_i) nrst_i = 1'b1;
      run(0, 0, 0, 8'hFF, 8'h00, 8'h00);
      run(0, 3, 0, 8'h01, 8'h00, 8'h00);
      run(1, 1, 0, 8'h7F, 8'h00, 8'h10);
      run(2, 2, 0, 8'h01, 8'h00, 8'h00);
      for (int k = 0; k < 2; k++) begin
         for (int o = 0; o < 6; o++) begin
            for (int s = 0; s < 4; s++) begin
               {rv, ri, ra} = 24'($urandom);
               run(o, s, 0, rv, ri, ra);
            end
         end
      end
      // Direct destinations, arithmetic forms too: flags must stay put
      for (int o = 0; o < 6; o++) begin
         for (int d = 1; d < 3; d++) begin
            {rv, ri, ra} = 24'($urandom);
            run(o, 1, d, rv, ri, ra);
         end
      end
      complete_run;
   end
   // Watchdog well beyond the expected run length
   initial begin
      #200000;
      err_count++;
      complete_run;
   end
endmodule
